// ===== plh_pkg.sv
package plh_pkg;
    // ==========================================
    // Field positions
    localparam int EN_BIT     = 63;
    localparam int LOWER_BIT  = 62;
    localparam int SDEF_BIT   = 61;
    localparam int FNS_BIT    = 60;
    localparam int IDTRP_BIT  = 58;
    localparam int TRAPU_BIT  = 49;
    localparam int TRAPK_BIT  = 48;
    localparam int LBL_W      = 48;
    // ==========================================
    // Encodings {op0,op1,CRn,CRm,op2}
    localparam logic [15:0] ENC_HYP = {2'h3, 3'h4, 4'ha, 4'h5, 3'h0};
    localparam logic [15:0] ENC_MON = {2'h3, 3'h6, 4'ha, 4'h5, 3'h0};
    localparam logic [15:0] ENC_KER = {2'h3, 3'h0, 4'ha, 4'h5, 3'h0};
    localparam logic [15:0] ENC_USR = {2'h3, 3'h0, 4'ha, 4'h5, 3'h1};
    localparam logic [15:0] ENC_ID  = {2'h3, 3'h0, 4'ha, 4'h4, 3'h4};
    // ==========================================
    // Misc constants
    localparam logic [5:0]  TRAP_EC   = 6'h18;
    localparam logic [11:0] NEST_SLOT = 12'h900;
    localparam logic [2:0]  NEST_ALL  = 3'h7;
    localparam logic [1:0]  EL0       = 2'h0;
    localparam logic [1:0]  EL1       = 2'h1;
    localparam logic [1:0]  EL2       = 2'h2;
    localparam logic [1:0]  EL3       = 2'h3;
    localparam logic        TRAPK_RST = 1'h1;
    localparam logic        LOWER_RST = 1'h1;
    // ==========================================
    // Access outcome and target
    typedef enum logic [2:0] {
        OC_MISS, OC_UNDEF, OC_TRAP2, OC_TRAP3, OC_LOCAL, OC_FWD, OC_NVMEM
    } plh_outcome_t;
    typedef enum logic [2:0] {
        TG_NONE, TG_HYP, TG_MON, TG_KER, TG_USR, TG_ID
    } plh_target_t;
endpackage : plh_pkg

// ===== plh_label_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// (RQ1) Enable 0 emits default labels at every level; 1 uses level register.
// (RQ2) Hyp enable bit writable without monitor level, else mirrors monitor bit.
// (RQ3) Warm reset clears the global enable.
// (RQ4) Id-trap bit or hyp-control id trap traps kernel id-register reads.
// (RQ5) Bit 49 traps kernel user-register access; warm reset sets it.
// (RQ6) Bit 48 traps kernel kernel-register access; same reset.
// (RQ7) Label fields: data group, instr group, data part, instr part.
// (RQ8) Labels always come live from registers, never cached.
// (RQ9) Hyp register: user undefined; kernel traps only with nested virt.
// (RQ10) Lower-trap sends hyp accesses to monitor; halted secure debug undefined.
// (RQ11) Hyp and monitor registers decoded at their system encodings.
// (RQ12) Hyp level with host extension redirects kernel register to hyp.
// (RQ13) Kernel with nested bits 111 uses nested memory slot 0x900.
// (RQ14) Monitor enable bit always read-write, the master copy.
// (RQ15) Lower-trap traps lower accesses that are not undefined to monitor; cold reset sets.
// (RQ16) Secure-default forces partition zero in secure state.
// (RQ17) Force-non-secure makes the non-secure label bit one when secure.
// (RQ18) Without the feature, hyp register accesses are undefined.
// (RQ19) Hyp register ignored when hyp level is not enabled.
// (RQ20) Monitor register only accessible at the monitor level.
// (RQ21) Capability flag says whether the id-trap bit exists.
module plh_label_regs #(
    parameter bit HAVE_EL3     = 1'b1,
    parameter bit HAS_FEAT     = 1'b1,
    parameter bit HAS_ID_TRAP  = 1'b1,
    parameter bit HAS_HCR      = 1'b1,
    parameter bit HAS_SEC_DEF  = 1'b1,
    parameter bit HAS_NS_FORCE = 1'b1,
    parameter bit NS_FORCE_RAO = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        coldRst,
    input  wire logic        sysReq,
    input  wire logic        sysWrite,
    input  wire logic [15:0] sysEnc,
    input  wire logic [63:0] sysWdata,
    input  wire logic [1:0]  curEl,
    input  wire logic        el2Enabled,
    input  wire logic        secureState,
    input  wire logic        halted,
    input  wire logic        secureDebugDisable,
    input  wire logic        hostExtensionBit,
    input  wire logic [2:0]  nestedVirtBits,
    input  wire logic        hypCtrlIdTrap,
    input  wire logic [47:0] lowerLabel,
    output logic             rspValid,
    output plh_pkg::plh_outcome_t rspKind,
    output plh_pkg::plh_target_t  rspTarget,
    output logic [5:0]       rspEc,
    output logic [63:0]      rspRdata,
    output logic [63:0]      rspWdata,
    output logic [11:0]      rspNestAddr,
    output logic             labelEnable,
    output logic             hasIdTrapFlag,
    output logic [15:0]      instrPartitionId,
    output logic [15:0]      dataPartitionId,
    output logic [7:0]       instrMonitorGroup,
    output logic [7:0]       dataMonitorGroup,
    output logic             nonsecureLabelBit
);
    // ==========================================
    // Register state
    logic        hypEn_reg;
    logic        idRegTrap_reg;
    logic        trapUserLabelReg_reg;
    logic        trapKernelLabelReg_reg;
    logic [47:0] hypLbl_reg;
    logic        monEn_reg;
    logic        lowerLevelTrap_reg;
    logic        secureDefaultPart_reg;
    logic        forceNonsecureLabel_reg;
    logic [47:0] monLbl_reg;

    logic        liveEn;
    logic        fnsBit;
    logic [63:0] hypView;
    logic [63:0] monView;
    plh_pkg::plh_target_t  tgt;
    plh_pkg::plh_outcome_t oc;
    plh_pkg::plh_outcome_t lowOc;
    logic [63:0] rdVal;
    logic        hypWr;
    logic        monWr;

    assign liveEn = HAVE_EL3 ? monEn_reg : hypEn_reg; // RQ2 RQ14
    assign fnsBit = NS_FORCE_RAO | forceNonsecureLabel_reg;

    always_comb begin
        hypView = '0;
        hypView[plh_pkg::EN_BIT]    = liveEn; // RQ2
        hypView[plh_pkg::IDTRP_BIT] = HAS_ID_TRAP & idRegTrap_reg; // RQ21
        hypView[plh_pkg::TRAPU_BIT] = trapUserLabelReg_reg;
        hypView[plh_pkg::TRAPK_BIT] = trapKernelLabelReg_reg;
        hypView[47:0]               = hypLbl_reg; // RQ7
        monView = '0;
        monView[plh_pkg::EN_BIT]    = monEn_reg;
        monView[plh_pkg::LOWER_BIT] = lowerLevelTrap_reg;
        monView[plh_pkg::SDEF_BIT]  = HAS_SEC_DEF & secureDefaultPart_reg;
        monView[plh_pkg::FNS_BIT]   = HAS_NS_FORCE & fnsBit;
        monView[47:0]               = monLbl_reg;
    end

    // ==========================================
    // Encoding decode
    always_comb begin
        case (sysEnc)
            plh_pkg::ENC_HYP: tgt = plh_pkg::TG_HYP; // RQ11
            plh_pkg::ENC_MON: tgt = plh_pkg::TG_MON; // RQ11
            plh_pkg::ENC_KER: tgt = plh_pkg::TG_KER;
            plh_pkg::ENC_USR: tgt = plh_pkg::TG_USR;
            plh_pkg::ENC_ID:  tgt = plh_pkg::TG_ID;
            default:          tgt = plh_pkg::TG_NONE;
        endcase
    end

    // ==========================================
    // Permission and trap decision
    always_comb begin
        if (HAVE_EL3 && lowerLevelTrap_reg) begin
            if (halted && secureDebugDisable) begin
                lowOc = plh_pkg::OC_UNDEF; // RQ10
            end else begin
                lowOc = plh_pkg::OC_TRAP3; // RQ15
            end
        end else begin
            lowOc = plh_pkg::OC_MISS;
        end
    end

    always_comb begin
        oc = plh_pkg::OC_MISS;
        case (tgt)
            plh_pkg::TG_HYP: begin
                if (!HAS_FEAT || curEl == plh_pkg::EL0) begin
                    oc = plh_pkg::OC_UNDEF; // RQ18 RQ9
                end else if (curEl == plh_pkg::EL1) begin
                    if (el2Enabled && nestedVirtBits[0]) begin
                        oc = (lowOc != plh_pkg::OC_MISS) ? lowOc : plh_pkg::OC_TRAP2; // RQ9
                    end else begin
                        oc = plh_pkg::OC_UNDEF; // RQ9
                    end
                end else if (curEl == plh_pkg::EL2) begin
                    oc = (lowOc != plh_pkg::OC_MISS) ? lowOc : plh_pkg::OC_LOCAL; // RQ10
                end else begin
                    oc = plh_pkg::OC_LOCAL;
                end
            end
            plh_pkg::TG_MON: begin
                oc = (HAS_FEAT && curEl == plh_pkg::EL3) ? plh_pkg::OC_LOCAL
                                                         : plh_pkg::OC_UNDEF; // RQ20
            end
            plh_pkg::TG_KER: begin
                if (curEl == plh_pkg::EL0) begin
                    oc = plh_pkg::OC_UNDEF;
                end else if (curEl == plh_pkg::EL3) begin
                    oc = plh_pkg::OC_FWD;
                end else if (lowOc != plh_pkg::OC_MISS) begin
                    oc = lowOc; // RQ15
                end else if (curEl == plh_pkg::EL1) begin
                    if (el2Enabled && trapKernelLabelReg_reg) begin
                        oc = plh_pkg::OC_TRAP2; // RQ6
                    end else if (el2Enabled && nestedVirtBits == plh_pkg::NEST_ALL) begin
                        oc = plh_pkg::OC_NVMEM; // RQ13
                    end else begin
                        oc = plh_pkg::OC_FWD;
                    end
                end else begin
                    oc = hostExtensionBit ? plh_pkg::OC_LOCAL : plh_pkg::OC_FWD; // RQ12
                end
            end
            plh_pkg::TG_USR: begin
                if (curEl == plh_pkg::EL0) begin
                    oc = plh_pkg::OC_UNDEF;
                end else if (curEl == plh_pkg::EL3) begin
                    oc = plh_pkg::OC_FWD;
                end else if (lowOc != plh_pkg::OC_MISS) begin
                    oc = lowOc; // RQ15
                end else if (curEl == plh_pkg::EL1 && el2Enabled && trapUserLabelReg_reg) begin
                    oc = plh_pkg::OC_TRAP2; // RQ5
                end else begin
                    oc = plh_pkg::OC_FWD;
                end
            end
            plh_pkg::TG_ID: begin
                if (curEl == plh_pkg::EL0 || sysWrite) begin
                    oc = plh_pkg::OC_UNDEF;
                end else if (curEl == plh_pkg::EL3) begin
                    oc = plh_pkg::OC_FWD;
                end else if (lowOc != plh_pkg::OC_MISS) begin
                    oc = lowOc; // RQ15
                end else if (curEl == plh_pkg::EL1 && el2Enabled
                             && ((HAS_HCR && hypCtrlIdTrap)
                                 || (HAS_ID_TRAP && idRegTrap_reg))) begin
                    oc = plh_pkg::OC_TRAP2; // RQ4
                end else begin
                    oc = plh_pkg::OC_FWD;
                end
            end
            default: oc = plh_pkg::OC_MISS;
        endcase
    end

    assign rdVal = (tgt == plh_pkg::TG_MON) ? monView : hypView;
    assign hypWr = sysReq && sysWrite && oc == plh_pkg::OC_LOCAL
                   && (tgt == plh_pkg::TG_HYP || tgt == plh_pkg::TG_KER); // RQ12
    assign monWr = sysReq && sysWrite && oc == plh_pkg::OC_LOCAL
                   && tgt == plh_pkg::TG_MON;

    // ==========================================
    // Response
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rspValid  <= 1'b0;
            rspKind   <= plh_pkg::OC_MISS;
            rspTarget <= plh_pkg::TG_NONE;
            rspEc     <= '0;
            rspRdata  <= '0;
            rspWdata  <= '0;
            rspNestAddr <= '0;
        end else begin
            rspValid  <= sysReq;
            rspKind   <= oc;
            rspTarget <= tgt;
            rspEc     <= (oc == plh_pkg::OC_TRAP2 || oc == plh_pkg::OC_TRAP3)
                         ? plh_pkg::TRAP_EC : 6'h00; // RQ9
            rspRdata  <= (oc == plh_pkg::OC_LOCAL && !sysWrite) ? rdVal : 64'h0;
            rspWdata  <= sysWdata;
            rspNestAddr <= (oc == plh_pkg::OC_NVMEM) ? plh_pkg::NEST_SLOT : 12'h000; // RQ13
        end
    end

    // ==========================================
    // Hypervisor register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hypEn_reg              <= 1'b0; // RQ3
            idRegTrap_reg          <= 1'b0;
            trapUserLabelReg_reg   <= plh_pkg::TRAPK_RST; // RQ5
            trapKernelLabelReg_reg <= plh_pkg::TRAPK_RST; // RQ6
        end else if (hypWr) begin
            if (!HAVE_EL3) begin
                hypEn_reg <= sysWdata[plh_pkg::EN_BIT]; // RQ2
            end
            idRegTrap_reg          <= HAS_ID_TRAP & sysWdata[plh_pkg::IDTRP_BIT]; // RQ21
            trapUserLabelReg_reg   <= sysWdata[plh_pkg::TRAPU_BIT];
            trapKernelLabelReg_reg <= sysWdata[plh_pkg::TRAPK_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (hypWr) begin
            hypLbl_reg <= sysWdata[plh_pkg::LBL_W-1:0]; // RQ7
        end
    end

    // ==========================================
    // Monitor register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            monEn_reg               <= 1'b0; // RQ3
            secureDefaultPart_reg   <= 1'b0;
            forceNonsecureLabel_reg <= 1'b0;
        end else if (monWr) begin
            monEn_reg               <= sysWdata[plh_pkg::EN_BIT]; // RQ14
            secureDefaultPart_reg   <= HAS_SEC_DEF & sysWdata[plh_pkg::SDEF_BIT];
            forceNonsecureLabel_reg <= HAS_NS_FORCE & sysWdata[plh_pkg::FNS_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n && coldRst) begin
            lowerLevelTrap_reg <= plh_pkg::LOWER_RST; // RQ15
        end else if (rst_n && monWr) begin
            lowerLevelTrap_reg <= sysWdata[plh_pkg::LOWER_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (monWr) begin
            monLbl_reg <= sysWdata[plh_pkg::LBL_W-1:0];
        end
    end

    // ==========================================
    // Live labelling, no cached copy
    logic [47:0] srcLbl;
    always_comb begin
        if (!liveEn) begin
            srcLbl = '0; // RQ1
        end else if (curEl == plh_pkg::EL3) begin
            srcLbl = monLbl_reg;
        end else if (curEl == plh_pkg::EL2) begin
            srcLbl = el2Enabled ? hypLbl_reg : 48'h0; // RQ19
        end else begin
            srcLbl = lowerLabel; // RQ1
        end
        if (secureState && HAS_SEC_DEF && secureDefaultPart_reg) begin
            srcLbl[31:0] = '0; // RQ16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            labelEnable       <= 1'b0;
            hasIdTrapFlag     <= 1'b0;
            instrPartitionId  <= '0;
            dataPartitionId   <= '0;
            instrMonitorGroup <= '0;
            dataMonitorGroup  <= '0;
            nonsecureLabelBit <= 1'b0;
        end else begin
            labelEnable       <= liveEn;
            hasIdTrapFlag     <= HAS_ID_TRAP; // RQ21
            instrPartitionId  <= srcLbl[15:0]; // RQ8
            dataPartitionId   <= srcLbl[31:16];
            instrMonitorGroup <= srcLbl[39:32];
            dataMonitorGroup  <= srcLbl[47:40];
            nonsecureLabelBit <= !secureState || (HAS_NS_FORCE && fnsBit); // RQ17
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    mon_el_only_a: assert property (sysReq && tgt == plh_pkg::TG_MON
        && curEl != plh_pkg::EL3 |=> rspKind == plh_pkg::OC_UNDEF) // RQ20
        else $error("monitor register reached below monitor level");
    default_label_a: assert property (!liveEn |=> dataPartitionId == 16'h0
        && instrMonitorGroup == 8'h0) // RQ1
        else $error("label not default while disabled");
    user_undef_a: assert property (sysReq && tgt == plh_pkg::TG_HYP
        && curEl == plh_pkg::EL0 |=> rspKind == plh_pkg::OC_UNDEF) // RQ9
        else $error("hyp register reachable from user level");
    trap_ec_a: assert property (rspKind == plh_pkg::OC_TRAP3 && rspValid
        |-> rspEc == 6'h18) // RQ9
        else $error("trap class wrong");
    lower_trap_a: assert property (sysReq && lowerLevelTrap_reg && HAVE_EL3 && !halted
        && curEl == plh_pkg::EL2 && tgt == plh_pkg::TG_HYP
        |=> rspKind == plh_pkg::OC_TRAP3) // RQ10
        else $error("lower trap not taken");
    nest_slot_a: assert property (rspKind == plh_pkg::OC_NVMEM && rspValid
        |-> rspNestAddr == 12'h900 && rspTarget == plh_pkg::TG_KER) // RQ13
        else $error("nested slot wrong");
    mirror_en_a: assert property (hypWr && HAVE_EL3 |=> $stable(liveEn)) // RQ2
        else $error("hyp write changed enable");
    warm_clear_a: assert property ($rose(rst_n) |-> !labelEnable) // RQ3
        else $error("enable not cleared");
    sec_part_a: assert property (secureState && secureDefaultPart_reg && HAS_SEC_DEF
        |=> instrPartitionId == 16'h0) // RQ16
        else $error("secure partition not forced");
    redirect_a: assert property (sysReq && !sysWrite && tgt == plh_pkg::TG_KER
        && curEl == plh_pkg::EL2 && hostExtensionBit && !lowerLevelTrap_reg
        |=> rspKind == plh_pkg::OC_LOCAL && rspRdata == $past(hypView)) // RQ12
        else $error("redirect failed");

    trap2_c: cover property (rspValid && rspKind == plh_pkg::OC_TRAP2);
    nvmem_c: cover property (rspValid && rspKind == plh_pkg::OC_NVMEM);
    monwr_c: cover property (monWr ##1 labelEnable);
endmodule : plh_label_regs

// ===== tb.sv
`timescale 1ns/1ns
module tb;
    // ==========================================
    // Stimulus and observation
    logic        clk;
    logic        rst_n;
    logic        coldRst;
    logic        sysReq;
    logic        sysWrite;
    logic [15:0] sysEnc;
    logic [63:0] sysWdata;
    logic [1:0]  curEl;
    logic        el2Enabled;
    logic        secureState;
    logic        halted;
    logic        secureDebugDisable;
    logic        hostExtensionBit;
    logic [2:0]  nestedVirtBits;
    logic        hypCtrlIdTrap;
    logic [47:0] lowerLabel;
    logic        rspValid;
    logic [5:0]  rspEc;
    logic [63:0] rspRdata;
    logic [63:0] rspWdata;
    logic [11:0] rspNestAddr;
    logic        labelEnable;
    logic        hasIdTrapFlag;
    logic [15:0] instrPartitionId;
    logic [15:0] dataPartitionId;
    logic [7:0]  instrMonitorGroup;
    logic [7:0]  dataMonitorGroup;
    logic        nonsecureLabelBit;
    int          mismatches;
    int          cmp_count;
    plh_pkg::plh_outcome_t rspKind;
    plh_pkg::plh_target_t  rspTarget;

    plh_label_regs u_dut (
        .clk(clk), .rst_n(rst_n), .coldRst(coldRst), .sysReq(sysReq),
        .sysWrite(sysWrite), .sysEnc(sysEnc), .sysWdata(sysWdata), .curEl(curEl),
        .el2Enabled(el2Enabled), .secureState(secureState), .halted(halted),
        .secureDebugDisable(secureDebugDisable), .hostExtensionBit(hostExtensionBit),
        .nestedVirtBits(nestedVirtBits), .hypCtrlIdTrap(hypCtrlIdTrap),
        .lowerLabel(lowerLabel), .rspValid(rspValid), .rspKind(rspKind),
        .rspTarget(rspTarget), .rspEc(rspEc), .rspRdata(rspRdata), .rspWdata(rspWdata),
        .rspNestAddr(rspNestAddr), .labelEnable(labelEnable), .hasIdTrapFlag(hasIdTrapFlag),
        .instrPartitionId(instrPartitionId), .dataPartitionId(dataPartitionId),
        .instrMonitorGroup(instrMonitorGroup), .dataMonitorGroup(dataMonitorGroup),
        .nonsecureLabelBit(nonsecureLabelBit)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic rst(input logic cold);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        coldRst = cold;
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        coldRst = 1'b0;
    endtask : rst

    // One access, answer judged one clock later
    task automatic acc(input logic w, input logic [15:0] e, input logic [63:0] d,
                       input logic [1:0] el, input plh_pkg::plh_outcome_t k);
        @(posedge clk);
        #1;
        sysReq = 1'b1;
        sysWrite = w;
        sysEnc = e;
        sysWdata = d;
        curEl = el;
        @(posedge clk);
        #1;
        sysReq = 1'b0;
        chk("rspValid", 64'h1, 64'(rspValid));
        chk("rspKind", 64'(k), 64'(rspKind));
        chk("rspEc", (k == plh_pkg::OC_TRAP2 || k == plh_pkg::OC_TRAP3) ? 64'h18 : 64'h0,
            64'(rspEc));
    endtask : acc

    task automatic wr(input logic [15:0] e, input logic [63:0] d);
        acc(1'b1, e, d, plh_pkg::EL3, plh_pkg::OC_LOCAL);
    endtask : wr

    task automatic rd(input logic [15:0] e, input logic [63:0] mask, input logic [63:0] exp);
        acc(1'b0, e, 64'h0, plh_pkg::EL3, plh_pkg::OC_LOCAL);
        chk("rspRdata", exp, rspRdata & mask);
    endtask : rd

    task automatic lbl(input logic [1:0] el, input logic [47:0] exp);
        curEl = el;
        repeat (2) @(posedge clk);
        #1;
        chk("label", 64'(exp), {16'h0, dataMonitorGroup, instrMonitorGroup,
                                dataPartitionId, instrPartitionId});
    endtask : lbl

    // ==========================================
    // Scenarios
    task automatic t_reset;
        rst(1'b1);
        chk("labelEnable", 64'h0, 64'(labelEnable));
        rd(plh_pkg::ENC_MON, 64'hc000_0000_0000_0000, 64'h4000_0000_0000_0000);
        chk("hasIdTrapFlag", 64'h1, 64'(hasIdTrapFlag));
        rd(plh_pkg::ENC_HYP, 64'h8003_0000_0000_0000, 64'h0003_0000_0000_0000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_enable;
        wr(plh_pkg::ENC_MON, 64'h8000_1234_5678_9abc);
        lbl(plh_pkg::EL3, 48'h1234_5678_9abc);
        chk("labelEnable", 64'h1, 64'(labelEnable));
        wr(plh_pkg::ENC_HYP, 64'h0000_aaaa_bbbb_cccc);
        rd(plh_pkg::ENC_HYP, 64'h8003_ffff_ffff_ffff, 64'h8000_aaaa_bbbb_cccc);
        lbl(plh_pkg::EL2, 48'haaaa_bbbb_cccc);
        lbl(plh_pkg::EL1, 48'h0102_0304_0506);
        el2Enabled = 1'b0;
        lbl(plh_pkg::EL2, 48'h0);
        el2Enabled = 1'b1;
        $display("enable test done");
    endtask : t_enable

    task automatic t_undef;
        for (int i = 0; i < 3; i++)
            acc(1'b0, plh_pkg::ENC_MON, 64'h0, 2'(i), plh_pkg::OC_UNDEF);
        acc(1'b0, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL0, plh_pkg::OC_UNDEF);
        acc(1'b0, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL1, plh_pkg::OC_UNDEF);
        nestedVirtBits = 3'h1;
        acc(1'b1, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP2);
        nestedVirtBits = 3'h0;
        acc(1'b0, 16'h0000, 64'h0, plh_pkg::EL3, plh_pkg::OC_MISS);
        acc(1'b1, plh_pkg::ENC_KER, 64'habcd, plh_pkg::EL3, plh_pkg::OC_FWD);
        chk("rspWdata", 64'habcd, rspWdata);
        chk("rspTarget", 64'(plh_pkg::TG_KER), 64'(rspTarget));
        $display("undefined access test done");
    endtask : t_undef

    task automatic t_traps;
        wr(plh_pkg::ENC_HYP, 64'h0403_0000_0000_0000);
        acc(1'b0, plh_pkg::ENC_USR, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP2);
        acc(1'b1, plh_pkg::ENC_KER, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP2);
        acc(1'b0, plh_pkg::ENC_ID, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP2);
        wr(plh_pkg::ENC_HYP, 64'h0000_1111_2222_3333);
        hypCtrlIdTrap = 1'b1;
        acc(1'b0, plh_pkg::ENC_ID, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP2);
        hypCtrlIdTrap = 1'b0;
        nestedVirtBits = 3'h7;
        acc(1'b0, plh_pkg::ENC_KER, 64'h0, plh_pkg::EL1, plh_pkg::OC_NVMEM);
        chk("rspNestAddr", 64'h900, 64'(rspNestAddr));
        chk("rspTarget", 64'(plh_pkg::TG_KER), 64'(rspTarget));
        nestedVirtBits = 3'h0;
        hostExtensionBit = 1'b1;
        acc(1'b0, plh_pkg::ENC_KER, 64'h0, plh_pkg::EL2, plh_pkg::OC_LOCAL);
        chk("rspRdata", 64'h0000_1111_2222_3333, rspRdata & 64'h0000_ffff_ffff_ffff);
        acc(1'b1, plh_pkg::ENC_KER, 64'h4444_5555_6666, plh_pkg::EL2, plh_pkg::OC_LOCAL);
        hostExtensionBit = 1'b0;
        rd(plh_pkg::ENC_HYP, 64'h0000_ffff_ffff_ffff, 64'h0000_4444_5555_6666);
        wr(plh_pkg::ENC_MON, 64'hc000_1234_5678_9abc);
        acc(1'b0, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL2, plh_pkg::OC_TRAP3);
        acc(1'b0, plh_pkg::ENC_KER, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP3);
        nestedVirtBits = 3'h1;
        acc(1'b0, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL1, plh_pkg::OC_TRAP3);
        nestedVirtBits = 3'h0;
        halted = 1'b1;
        secureDebugDisable = 1'b1;
        acc(1'b1, plh_pkg::ENC_HYP, 64'h0, plh_pkg::EL2, plh_pkg::OC_UNDEF);
        halted = 1'b0;
        secureDebugDisable = 1'b0;
        $display("trap test done");
    endtask : t_traps

    task automatic t_secure;
        secureState = 1'b1;
        wr(plh_pkg::ENC_MON, 64'ha000_1234_5678_9abc);
        lbl(plh_pkg::EL3, 48'h1234_0000_0000);
        chk("nonsecureLabelBit", 64'h0, 64'(nonsecureLabelBit));
        wr(plh_pkg::ENC_MON, 64'h9000_1234_5678_9abc);
        lbl(plh_pkg::EL3, 48'h1234_5678_9abc);
        chk("nonsecureLabelBit", 64'h1, 64'(nonsecureLabelBit));
        secureState = 1'b0;
        wr(plh_pkg::ENC_MON, 64'h0000_1234_5678_9abc);
        lbl(plh_pkg::EL3, 48'h0);
        chk("nonsecureLabelBit", 64'h1, 64'(nonsecureLabelBit));
        $display("secure state test done");
    endtask : t_secure

    task automatic t_warm;
        wr(plh_pkg::ENC_MON, 64'h8000_0000_0000_0000);
        rst(1'b0);
        chk("labelEnable", 64'h0, 64'(labelEnable));
        rd(plh_pkg::ENC_MON, 64'hc000_0000_0000_0000, 64'h0);
        $display("warm reset test done");
    endtask : t_warm

    // ==========================================
    // Main sequence
    initial begin
        mismatches = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        coldRst = 1'b1;
        sysReq = 1'b0;
        sysWrite = 1'b0;
        sysEnc = 16'h0;
        sysWdata = 64'h0;
        curEl = plh_pkg::EL3;
        el2Enabled = 1'b1;
        secureState = 1'b0;
        halted = 1'b0;
        secureDebugDisable = 1'b0;
        hostExtensionBit = 1'b0;
        nestedVirtBits = 3'h0;
        hypCtrlIdTrap = 1'b0;
        lowerLabel = 48'h0102_0304_0506;
        t_reset();
        t_enable();
        t_undef();
        t_traps();
        t_secure();
        t_warm();
        give_verdict();
    end

    // Hang guard
    initial begin
        #100000;
        mismatches++;
        $display("[FAIL] run time expected below limit seen limit reached");
        give_verdict();
    end
endmodule : tb
